// ==== inc/burner_status_pkg.sv ====
/*
 * Shared constants of the burner extended status bank: register numbers,
 * packed status word layout, counter slots and values after reset.
 * Assumes register numbers are the holding-register numbers seen by the master.
 */
package burner_status_pkg;

    // Width of a holding-register number and of a register
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;

    // Holding-register numbers of the extended area
    localparam logic [15:0] RUNTIME_METER_BYTE0  = 16'h0004;
    localparam logic [15:0] RUNTIME_METER_BYTE1  = 16'h0005;
    localparam logic [15:0] RUNTIME_METER_BYTE2  = 16'h0006;
    localparam logic [15:0] RUNTIME_METER_BYTE3  = 16'h0007;
    localparam logic [15:0] START_COUNTER_BYTE0  = 16'h0008;
    localparam logic [15:0] START_COUNTER_BYTE1  = 16'h0009;
    localparam logic [15:0] START_COUNTER_BYTE2  = 16'h000A;
    localparam logic [15:0] START_COUNTER_BYTE3  = 16'h000B;
    localparam logic [15:0] VALVE2_CYCLES_BYTE0  = 16'h000C;
    localparam logic [15:0] VALVE2_CYCLES_BYTE1  = 16'h000D;
    localparam logic [15:0] VALVE2_CYCLES_BYTE2  = 16'h000E;
    localparam logic [15:0] VALVE2_CYCLES_BYTE3  = 16'h000F;
    localparam logic [15:0] VALVE2_RUNTIME_BYTE0 = 16'h0010;
    localparam logic [15:0] VALVE2_RUNTIME_BYTE1 = 16'h0011;
    localparam logic [15:0] VALVE2_RUNTIME_BYTE2 = 16'h0012;
    localparam logic [15:0] VALVE2_RUNTIME_BYTE3 = 16'h0013;
    localparam logic [15:0] FAULT_DETAIL_BYTE    = 16'h0014;
    localparam logic [15:0] PACKED_STATUS_WORD   = 16'h0015;

    // First and last register of the counter span
    localparam logic [15:0] COUNTER_FIRST = RUNTIME_METER_BYTE0;
    localparam logic [15:0] COUNTER_LAST  = VALVE2_RUNTIME_BYTE3;

    // Counter slots in the snapshot, in register order
    localparam logic [1:0] SLOT_RUNTIME   = 2'h0;
    localparam logic [1:0] SLOT_STARTS    = 2'h1;
    localparam logic [1:0] SLOT_V2_CYCLES = 2'h2;
    localparam logic [1:0] SLOT_V2_RUNTIME = 2'h3;
    localparam int unsigned NUM_COUNTERS = 4;
    localparam int unsigned COUNTER_W    = 32;

    // Bit positions in the packed status word
    localparam int unsigned ST_FLAME1       = 0;
    localparam int unsigned ST_FLAME2       = 1;
    localparam int unsigned ST_FLAME2_NC    = 2;
    localparam int unsigned ST_FLAME_RESULT = 3;
    localparam int unsigned ST_AIR_PRESSURE = 4;
    localparam int unsigned ST_TEMP_HW      = 5;
    localparam int unsigned ST_VALVE1       = 6;
    localparam int unsigned ST_VALVE2       = 7;
    localparam int unsigned ST_IGNITION     = 8;
    localparam int unsigned ST_MANUAL       = 9;
    localparam int unsigned ST_FAN          = 10;
    localparam int unsigned ST_UNUSED11     = 11;
    localparam int unsigned ST_TEMP_COMB    = 12;
    localparam int unsigned ST_UNUSED13     = 13;
    localparam int unsigned ST_UNUSED14     = 14;
    localparam int unsigned ST_FAULT        = 15;

    // Values after reset
    localparam logic [15:0] RDATA_RST   = 16'h0000;
    localparam logic [31:0] SNAP_RST    = 32'h0000_0000;
    localparam logic [7:0]  UPPER_ZERO  = 8'h00;

endpackage

// ==== inc/snap_if.sv ====
/*
 * Carrier between the register bank and its counter snapshot store.
 * Assumes one clock domain; capture is a one-cycle strobe.
 */
`timescale 1ns/100ps
interface snap_if;
    logic                   capture;   // Take a new copy of all counters
    logic [3:0][31:0]       words;     // Frozen counter values

    modport ctrl  (output capture, input  words);
    modport store (input  capture, output words);
endinterface

// ==== design/counter_snapshot.sv ====
/*
 * Holds a frozen copy of the four 32-bit counters, taken on one strobe.
 * Assumes the live counters are synchronous to clk_in.
 */
`timescale 1ns/100ps
module counter_snapshot #(
    parameter int unsigned NUM = 4
) (
    input  wire logic                  clk_in,
    input  wire logic                  rst_in,
    input  wire logic [NUM-1:0][31:0]  live_in,
    snap_if.store                      snap
);

    // One frozen word per counter, all loaded by the same strobe
    genvar gi;
    generate
        for (gi = 0; gi < NUM; gi++) begin : g_slot
            logic [31:0] word_r;   // Frozen copy
            // All slots share one edge, so bytes never mix epochs
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    word_r <= burner_status_pkg::SNAP_RST;
                end else if (snap.capture) begin
                    word_r <= live_in[gi];
                end
            end
            assign snap.words[gi] = word_r;
        end
    endgenerate

    // Copy only moves on a capture strobe
    property p_snap_hold;
        @(posedge clk_in) disable iff (rst_in)
        !snap.capture |=> $stable(snap.words);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved");

    // A capture lands the live values one edge later
    property p_snap_load;
        @(posedge clk_in) disable iff (rst_in)
        snap.capture |=> snap.words == $past(live_in);
    endproperty
    a_snap_load: assert property (p_snap_load) else $error("snapshot not loaded");

endmodule

// ==== design/burner_ext_status.sv ====
/*
 * Extended read-only status bank of a burner controller: four 32-bit
 * counters shown a byte per register, a fault detail byte and a packed
 * status word, served to the fieldbus register read path.
 * Assumes the protocol engine in front of it decodes holding-register
 * reads into one strobe per register and marks each new request frame.
 */
// Functional notes
// - Runtime seconds bytes in registers four to seven
// - Start count bytes in registers eight to eleven
// - Valve two cycle bytes in registers twelve-fifteen
// - Valve two runtime bytes in registers sixteen-nineteen
// - Fault detail byte register twenty, readable during fault
// - Upper byte of registers four-twenty reads zero
// - Status word bits zero-seven: flames, air, temperature pin, valves
// - Ignition, manual, fan, fault; unused bits zero
// - Bit twelve combines hardware and bus demand
// - Fault forces flame one bit to zero

`timescale 1ns/100ps
module burner_ext_status (
    input  wire logic        CLK_IN,                // 200 MHz system clock
    input  wire logic        SYS_RST_IN,            // Async reset, active high
    // Register access from the protocol engine
    input  wire logic        FRAME_START_IN,        // New request frame begins
    input  wire logic        REG_RD_IN,             // Read one register
    input  wire logic        REG_WR_IN,             // Write one register
    input  wire logic [15:0] REG_ADDR_IN,           // Register number
    input  wire logic [15:0] REG_WDATA_IN,          // Write data, discarded
    output      logic [15:0] REG_RDATA_OUT,         // Read data
    output      logic        REG_RVALID_OUT,        // Read answer pulse
    output      logic        REG_ERR_OUT,           // Refused access pulse
    // Live counters from the sequencer
    input  wire logic [31:0] RUNTIME_SEC_IN,        // Burner runtime in s
    input  wire logic [31:0] START_COUNT_IN,        // Burner starts
    input  wire logic [31:0] VALVE2_CYCLES_IN,      // Second valve switchings
    input  wire logic [31:0] VALVE2_RUNTIME_SEC_IN, // Second valve runtime in s
    input  wire logic [7:0]  FAULT_DETAIL_IN,       // First extra fault byte
    // Live status levels
    input  wire logic        FLAME1_IN,             // Flame one seen
    input  wire logic        FLAME2_IN,             // Flame two seen
    input  wire logic        FLAME2_NC_IN,          // Flame two NC signal
    input  wire logic        FLAME_RESULT_IN,       // Resulting flame
    input  wire logic        AIR_PRESSURE_OK_IN,    // Air pressure sufficient
    input  wire logic        TEMP_CTRL_HW_IN,       // Temperature input pin
    input  wire logic        FIRST_GAS_VALVE_IN,    // First valve open
    input  wire logic        SECOND_GAS_VALVE_IN,   // Second valve open
    input  wire logic        IGNITION_IN,           // Ignition active
    input  wire logic        MANUAL_OP_IN,          // Manual operation
    input  wire logic        FAN_RELAY_IN,          // Fan relay energised
    input  wire logic        FAULT_IN,              // Controller in fault
    input  wire logic        BUS_TEMP_REQ_IN        // Demand written by master
);

    // Snapshot carrier
    snap_if snap ();

    // Live counters gathered in slot order
    logic [3:0][31:0] live_w;                 // Counter vector for the store
    assign live_w[burner_status_pkg::SLOT_RUNTIME]    = RUNTIME_SEC_IN;
    assign live_w[burner_status_pkg::SLOT_STARTS]     = START_COUNT_IN;
    assign live_w[burner_status_pkg::SLOT_V2_CYCLES]  = VALVE2_CYCLES_IN;
    assign live_w[burner_status_pkg::SLOT_V2_RUNTIME] = VALVE2_RUNTIME_SEC_IN;

    // Freeze on frame start: a multi-register read sees one epoch
    assign snap.capture = FRAME_START_IN;

    counter_snapshot #(
        .NUM     (burner_status_pkg::NUM_COUNTERS)
    ) u_snap (
        .clk_in  (CLK_IN),
        .rst_in  (SYS_RST_IN),
        .live_in (live_w),
        .snap    (snap.store)
    );

    // Combined temperature demand; either source can ask for heat
    logic temp_comb_w;                        // Evaluated demand
    assign temp_comb_w = TEMP_CTRL_HW_IN | BUS_TEMP_REQ_IN;

    // Flame one is masked while in fault, the rest stays live
    logic flame1_shown_w;                     // Flame one as reported
    assign flame1_shown_w = FLAME1_IN & ~FAULT_IN;

    // Packed status word
    logic [15:0] status_w;                    // Register twenty-one image
    assign status_w[burner_status_pkg::ST_FLAME1]       = flame1_shown_w;
    assign status_w[burner_status_pkg::ST_FLAME2]       = FLAME2_IN;
    assign status_w[burner_status_pkg::ST_FLAME2_NC]    = FLAME2_NC_IN;
    assign status_w[burner_status_pkg::ST_FLAME_RESULT] = FLAME_RESULT_IN;
    assign status_w[burner_status_pkg::ST_AIR_PRESSURE] = AIR_PRESSURE_OK_IN;
    assign status_w[burner_status_pkg::ST_TEMP_HW]      = TEMP_CTRL_HW_IN;
    assign status_w[burner_status_pkg::ST_VALVE1]       = FIRST_GAS_VALVE_IN;
    assign status_w[burner_status_pkg::ST_VALVE2]       = SECOND_GAS_VALVE_IN;
    assign status_w[burner_status_pkg::ST_IGNITION]     = IGNITION_IN;
    assign status_w[burner_status_pkg::ST_MANUAL]       = MANUAL_OP_IN;
    assign status_w[burner_status_pkg::ST_FAN]          = FAN_RELAY_IN;
    assign status_w[burner_status_pkg::ST_UNUSED11]     = 1'b0;
    assign status_w[burner_status_pkg::ST_TEMP_COMB]    = temp_comb_w;
    assign status_w[burner_status_pkg::ST_UNUSED13]     = 1'b0;
    assign status_w[burner_status_pkg::ST_UNUSED14]     = 1'b0;
    assign status_w[burner_status_pkg::ST_FAULT]        = FAULT_IN;

    // Address decode
    logic [15:0] rel_w;                       // Offset into counter span
    logic [1:0]  slot_w;                      // Which counter
    logic [1:0]  lane_w;                      // Which byte, zero is least
    logic        hit_cnt_w;                   // Counter register hit
    logic        hit_detail_w;                // Fault detail register hit
    logic        hit_status_w;                // Packed status register hit
    logic        mapped_w;                    // Any register of this bank
    assign rel_w        = REG_ADDR_IN - burner_status_pkg::COUNTER_FIRST;
    assign slot_w       = rel_w[3:2];
    assign lane_w       = rel_w[1:0];
    assign hit_cnt_w    = (REG_ADDR_IN >= burner_status_pkg::COUNTER_FIRST) &&
                          (REG_ADDR_IN <= burner_status_pkg::COUNTER_LAST);
    assign hit_detail_w = REG_ADDR_IN == burner_status_pkg::FAULT_DETAIL_BYTE;
    assign hit_status_w = REG_ADDR_IN == burner_status_pkg::PACKED_STATUS_WORD;
    assign mapped_w     = hit_cnt_w | hit_detail_w | hit_status_w;

    // Byte picked from the frozen copy, least significant byte first
    logic [31:0] slot_word_w;                 // Selected frozen counter
    logic [7:0]  cnt_byte_w;                  // Selected byte of it
    assign slot_word_w = snap.words[slot_w];
    assign cnt_byte_w  = slot_word_w[{lane_w, 3'h0} +: 8];

    // Read mux; upper byte is zero everywhere but the packed word
    logic [15:0] rd_word_w;                   // Data for the addressed register
    assign rd_word_w = hit_cnt_w    ? {burner_status_pkg::UPPER_ZERO, cnt_byte_w} :
                       hit_detail_w ? {burner_status_pkg::UPPER_ZERO, FAULT_DETAIL_IN} :
                       hit_status_w ? status_w :
                                      burner_status_pkg::RDATA_RST;

    // Answer next values; a write without a read is refused, nothing is stored
    logic [15:0] rdata_nxt;                   // Next read data
    logic        rvalid_nxt;                  // Next answer pulse
    logic        err_nxt;                     // Next refusal pulse
    assign rdata_nxt  = (REG_RD_IN && mapped_w) ? rd_word_w : burner_status_pkg::RDATA_RST;
    assign rvalid_nxt = REG_RD_IN;
    assign err_nxt    = (REG_RD_IN && !mapped_w) || (REG_WR_IN && !REG_RD_IN);

    // Answer registers; the write data port reaches no storage at all
    logic [15:0] rdata_r;                     // Read data flop
    logic        rvalid_r;                    // Answer pulse flop
    logic        err_r;                       // Refusal pulse flop
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            rdata_r  <= burner_status_pkg::RDATA_RST;
            rvalid_r <= 1'b0;
            err_r    <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            err_r    <= err_nxt;
        end
    end

    assign REG_RDATA_OUT  = rdata_r;
    assign REG_RVALID_OUT = rvalid_r;
    assign REG_ERR_OUT    = err_r;

    // Checks

    // Frame start, then a plain read of register a
    sequence s_cap_rd(logic [15:0] a);
        FRAME_START_IN ##1 (REG_RD_IN && !FRAME_START_IN && REG_ADDR_IN == a);
    endsequence

    // Runtime top byte comes from the frame-start value
    property p_runtime_b3;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::RUNTIME_METER_BYTE3) |=>
            REG_RVALID_OUT && REG_RDATA_OUT[7:0] == $past(RUNTIME_SEC_IN[31:24], 2);
    endproperty
    a_runtime_b3: assert property (p_runtime_b3) else $error("runtime byte3 wrong");

    // Runtime low byte
    property p_runtime_b0;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::RUNTIME_METER_BYTE0) |=>
            REG_RDATA_OUT[7:0] == $past(RUNTIME_SEC_IN[7:0], 2);
    endproperty
    a_runtime_b0: assert property (p_runtime_b0) else $error("runtime byte0 wrong");

    // Runtime byte one
    property p_runtime_b1;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::RUNTIME_METER_BYTE1) |=>
            REG_RDATA_OUT[7:0] == $past(RUNTIME_SEC_IN[15:8], 2);
    endproperty
    a_runtime_b1: assert property (p_runtime_b1) else $error("runtime byte1 wrong");

    // Runtime byte two
    property p_runtime_b2;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::RUNTIME_METER_BYTE2) |=>
            REG_RDATA_OUT[7:0] == $past(RUNTIME_SEC_IN[23:16], 2);
    endproperty
    a_runtime_b2: assert property (p_runtime_b2) else $error("runtime byte2 wrong");

    // Start counter low byte
    property p_starts_b0;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::START_COUNTER_BYTE0) |=>
            REG_RDATA_OUT[7:0] == $past(START_COUNT_IN[7:0], 2);
    endproperty
    a_starts_b0: assert property (p_starts_b0) else $error("start byte0 wrong");

    // Start counter top byte
    property p_starts_b3;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::START_COUNTER_BYTE3) |=>
            REG_RDATA_OUT[7:0] == $past(START_COUNT_IN[31:24], 2);
    endproperty
    a_starts_b3: assert property (p_starts_b3) else $error("start byte3 wrong");

    // Valve two cycles low byte
    property p_v2cyc_b0;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::VALVE2_CYCLES_BYTE0) |=>
            REG_RDATA_OUT[7:0] == $past(VALVE2_CYCLES_IN[7:0], 2);
    endproperty
    a_v2cyc_b0: assert property (p_v2cyc_b0) else $error("cycles byte0 wrong");

    // Valve two cycles top byte
    property p_v2cyc_b3;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::VALVE2_CYCLES_BYTE3) |=>
            REG_RDATA_OUT[7:0] == $past(VALVE2_CYCLES_IN[31:24], 2);
    endproperty
    a_v2cyc_b3: assert property (p_v2cyc_b3) else $error("cycles byte3 wrong");

    // Valve two runtime byte one
    property p_v2run_b1;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::VALVE2_RUNTIME_BYTE1) |=>
            REG_RDATA_OUT[7:0] == $past(VALVE2_RUNTIME_SEC_IN[15:8], 2);
    endproperty
    a_v2run_b1: assert property (p_v2run_b1) else $error("v2 runtime byte1 wrong");

    // Valve two runtime top byte
    property p_v2run_b3;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        s_cap_rd(burner_status_pkg::VALVE2_RUNTIME_BYTE3) |=>
            REG_RDATA_OUT[7:0] == $past(VALVE2_RUNTIME_SEC_IN[31:24], 2);
    endproperty
    a_v2run_b3: assert property (p_v2run_b3) else $error("v2 runtime byte3 wrong");

    // Fault detail is served live, also in fault
    property p_detail;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        REG_RD_IN && REG_ADDR_IN == burner_status_pkg::FAULT_DETAIL_BYTE |=>
            REG_RVALID_OUT && !REG_ERR_OUT &&
            REG_RDATA_OUT == {8'h00, $past(FAULT_DETAIL_IN)};
    endproperty
    a_detail: assert property (p_detail) else $error("fault detail wrong");

    // Upper byte is zero for every answer but the packed word
    property p_upper_zero;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        REG_RVALID_OUT && $past(REG_ADDR_IN) != burner_status_pkg::PACKED_STATUS_WORD |->
            REG_RDATA_OUT[15:8] == 8'h00;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");

    // Packed word read returns the live image in bits one to seven, flame two to valve two
    property p_status_rd;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        REG_RD_IN && hit_status_w |=>
            REG_RDATA_OUT[7:1] == {$past(SECOND_GAS_VALVE_IN), $past(FIRST_GAS_VALVE_IN),
                                   $past(TEMP_CTRL_HW_IN), $past(AIR_PRESSURE_OK_IN),
                                   $past(FLAME_RESULT_IN), $past(FLAME2_NC_IN),
                                   $past(FLAME2_IN)};
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status low bits wrong");

    // Unused bits zero and fault bit follows the fault level
    property p_status_hi;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        status_w[15] == FAULT_IN && status_w[14:13] == 2'h0 && !status_w[11] &&
        status_w[10:8] == {FAN_RELAY_IN, MANUAL_OP_IN, IGNITION_IN};
    endproperty
    a_status_hi: assert property (p_status_hi) else $error("status high bits wrong");

    // Combined demand on bit twelve
    property p_temp_comb;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        REG_RD_IN && hit_status_w |=>
            REG_RDATA_OUT[12] == ($past(TEMP_CTRL_HW_IN) | $past(BUS_TEMP_REQ_IN));
    endproperty
    a_temp_comb: assert property (p_temp_comb) else $error("combined demand wrong");

    // Fault masks flame one in the answer
    property p_fault_flame;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        REG_RD_IN && hit_status_w && FAULT_IN |=> !REG_RDATA_OUT[0] && REG_RDATA_OUT[15];
    endproperty
    a_fault_flame: assert property (p_fault_flame) else $error("flame1 shown in fault");

    // A write is refused without a read answer and leaves the frozen counters untouched
    property p_write_inert;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        REG_WR_IN && !REG_RD_IN && !FRAME_START_IN |=>
            REG_ERR_OUT && !REG_RVALID_OUT && $stable(snap.words);
    endproperty
    a_write_inert: assert property (p_write_inert) else $error("write had effect");

    // A refused write never leaks data onto the answer bus
    property p_write_nodata;
        @(posedge CLK_IN) disable iff (SYS_RST_IN)
        REG_WR_IN && !REG_RD_IN |=> REG_RDATA_OUT == 16'h0000;
    endproperty
    a_write_nodata: assert property (p_write_nodata) else $error("write gave data");

endmodule

// ==== testbench/modbus_poll_model.sv ====
/*
 * Polling master in front of the status bank: capture strobe plus single
 * register reads and writes, one request a call.
 * Assumes the bank answers on the taking edge, sampled half a cycle later.
 */
`timescale 1ns/100ps
module modbus_poll_model (
    input  wire logic        clk_in,    // System clock
    input  wire logic [15:0] rdata_in,  // Answer data
    input  wire logic        rvalid_in, // Answer pulse
    input  wire logic        err_in,    // Refusal pulse
    output      logic        frame_out, // New request frame
    output      logic        rd_out,    // Read strobe
    output      logic        wr_out,    // Write strobe
    output      logic [15:0] addr_out,  // Register number
    output      logic [15:0] wdata_out  // Write data
);
    // Idle request lines from time zero
    initial begin
        frame_out = 1'b0;
        rd_out    = 1'b0;
        wr_out    = 1'b0;
        addr_out  = 16'h5A5A;
        wdata_out = 16'hC33C;
    end

    // Frame marker; the next access lowers it, so its read follows directly
    task automatic frame();
        @(negedge clk_in);
        frame_out = 1'b1;
    endtask

    // Holding-register access; address inverted afterwards so stale values never match
    task automatic xfer(input logic w, input logic [15:0] a, output logic [15:0] d,
                        output logic v, output logic e);
        @(negedge clk_in);
        frame_out = 1'b0;
        rd_out    = ~w;
        wr_out    = w;
        addr_out  = a;
        wdata_out = 16'hFFFF;
        @(negedge clk_in);
        d         = rdata_in;
        v         = rvalid_in;
        e         = err_in;
        rd_out    = 1'b0;
        wr_out    = 1'b0;
        addr_out  = ~a;
        wdata_out = 16'h0000;
    endtask
endmodule

// ==== testbench/burner_ext_status_tb.sv ====
/*
 * Self-checking bench of the extended status bank: counter bytes, capture,
 * fault byte, packed word, refused writes and unmapped reads.
 * Assumes the package, interface, design and polling model compile first.
 */
`timescale 1ns/100ps
module burner_ext_status_tb;
    logic             clk;         // 200 MHz clock
    logic             rst;         // Async reset, high
    logic             frame_start; // Capture strobe
    logic             rd;          // Read strobe
    logic             wr;          // Write strobe
    logic [15:0]      addr;        // Register number
    logic [15:0]      wdata;       // Write data
    logic [15:0]      rdata;       // Answer data
    logic             rvalid;      // Answer pulse
    logic             err;         // Refusal pulse
    logic [3:0][31:0] cnt;         // Live counters
    logic [3:0][31:0] snap;        // Counters at last capture
    logic [7:0]       fdet;        // Fault detail byte
    logic [12:0]      st;          // Status levels, fault at 11, bus demand at 12
    logic [12:0]      pats [7];    // Status patterns
    int               n_errors;    // Mismatches
    int               num_checks;  // Comparisons

    burner_ext_status uut (.CLK_IN(clk), .SYS_RST_IN(rst), .FRAME_START_IN(frame_start),
        .REG_RD_IN(rd), .REG_WR_IN(wr), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .REG_ERR_OUT(err),
        .RUNTIME_SEC_IN(cnt[0]), .START_COUNT_IN(cnt[1]), .VALVE2_CYCLES_IN(cnt[2]),
        .VALVE2_RUNTIME_SEC_IN(cnt[3]), .FAULT_DETAIL_IN(fdet), .FLAME1_IN(st[0]),
        .FLAME2_IN(st[1]), .FLAME2_NC_IN(st[2]), .FLAME_RESULT_IN(st[3]),
        .AIR_PRESSURE_OK_IN(st[4]), .TEMP_CTRL_HW_IN(st[5]), .FIRST_GAS_VALVE_IN(st[6]),
        .SECOND_GAS_VALVE_IN(st[7]), .IGNITION_IN(st[8]), .MANUAL_OP_IN(st[9]),
        .FAN_RELAY_IN(st[10]), .FAULT_IN(st[11]), .BUS_TEMP_REQ_IN(st[12]));

    modbus_poll_model mst (.clk_in(clk), .rdata_in(rdata), .rvalid_in(rvalid),
        .err_in(err), .frame_out(frame_start), .rd_out(rd), .wr_out(wr),
        .addr_out(addr), .wdata_out(wdata));

    // Free-running clock
    initial clk = 1'b0;
    always #2.5 clk = ~clk;

    // Packed word as the bank should show it; only flame one is masked in fault
    function automatic logic [15:0] exp21(input logic [12:0] s);
        return {s[11], 2'b00, s[5] | s[12], 1'b0, s[10:1], s[0] & ~s[11]};
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One access, then data and {valid, error} compared
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] exp,
                       input logic [1:0] fl);
        logic [15:0] d;
        logic        v;
        logic        e;
        mst.xfer(w, a, d, v, e);
        chk("read data", exp, d);
        chk("valid and error", {14'h0000, fl}, {14'h0000, v, e});
    endtask

    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run is under a hundred cycles; this cuts a hang short
    initial begin
        #50000;
        n_errors++;
        complete_run();
    end

    initial begin
        rst        = 1'b1;
        cnt        = {32'hF1E2D3C4, 32'h8091A2B3, 32'h55667788, 32'h12345678};
        fdet       = 8'h00;
        st         = 13'h0000;
        n_errors   = 0;
        num_checks = 0;
        pats = '{13'h07FF, 13'h0FFF, 13'h1000, 13'h0020, 13'h0555, 13'h1AAA, 13'h0801};
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        // All sixteen counter bytes, upper byte zero
        snap = cnt;
        for (int r = 4; r < 20; r++) begin
            mst.frame();
            acc(1'b0, 16'(r), {8'h00, snap[(r-4)/4][8*((r-4)%4) +: 8]}, 2'b10);
        end
        // Live change without a frame stays hidden until the next capture
        cnt[0] = 32'hA0B0C0D0;
        acc(1'b0, 16'h0007, {8'h00, snap[0][31:24]}, 2'b10);
        mst.frame();
        acc(1'b0, 16'h0007, 16'h00A0, 2'b10);
        // Writes refused and leave contents alone
        acc(1'b1, 16'h0004, 16'h0000, 2'b01);
        acc(1'b1, 16'h0015, 16'h0000, 2'b01);
        acc(1'b0, 16'h0004, 16'h00D0, 2'b10);
        // Fault byte while a fault is active
        fdet = 8'hA5;
        st   = 13'h0801;
        acc(1'b0, 16'h0014, 16'h00A5, 2'b10);
        // Packed word across patterns, fault masking and combined demand
        for (int i = 0; i < 7; i++) begin
            st = pats[i];
            acc(1'b0, 16'h0015, exp21(pats[i]), 2'b10);
        end
        // Reads just outside the bank
        acc(1'b0, 16'h0003, 16'h0000, 2'b11);
        acc(1'b0, 16'h0016, 16'h0000, 2'b11);
        complete_run();
    end
endmodule
